// File: design/charger_i2c_slave.sv
// Summary of operation
// R01 - sda falling while scl high starts transfer
// R02 - master sends address plus direction byte
// R03 - sda changes only while scl low
// R04 - matching address acked low through ninth high
// R05 - every byte followed by receiver acknowledge
// R06 - stop releases bus, slave waits start
// R07 - master stops abandoned transfers to reset
// R08 - unmapped register reads return ffh
// R09 - master sends code 00001xxx at fs
// R10 - code never acked, switches to hs
// R11 - repeated start follows code, then hs protocol
// R12 - stop returns slave to fs mode
// R13 - master prefers repeated starts in hs
// R14 - write is start, address, register, data
// R15 - commit on falling edge ending ack
// R16 - further updates need register and data only
// R17 - five registers, four writable, one read-only
// R18 - b7 write kicks timer, reads pin
// R19 - b6 enables status pin, resets one
// R20 - b5:b4 report charge state
// R21 - b3 boost flag, reset zero
// R22 - b2:b0 hold fault code
// R23 - fixed seven-bit address per variant
// R24 - direction zero writes, one reads
`timescale 1ns/1ps
`include "chg_link_defines.svh"
module charger_i2c_slave
    import chg_link_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `SLV_ADDR_A,  // variant address
    parameter logic [7:0] PART_ID    = 8'h00         // arbitrary value
) (
    input  wire logic   clk,                   // 40 mhz clock
    input  wire logic   sys_rst,               // sync reset, high
    i2c_link_if.slave   link,                  // two-wire bus
    input  wire logic   boost_request_pin,     // mode-request pin
    input  wire logic [1:0] charge_state,      // charger state code
    input  wire logic   boost_active,          // boost mode flag
    input  wire logic [2:0] fault_code,        // fault code
    output logic        safety_timer_restart,  // one-cycle kick
    output logic        stat_pin_enable,       // status pin enable
    output logic        hs_mode                // high-speed mode
);
    import chg_link_pkg::*;

    typedef struct packed {
        dev_state_t state;
        byte_kind_t kind;
        logic       rd;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] pin_s;
        logic       scl_f;
        logic       sda_f;
        logic       pin_f;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic [5:0] snap;
        logic       stat_en;
        logic [7:0] r1;
        logic [7:0] r2;
        logic [7:0] r4;
        logic       kick;
        logic       hs;
        logic       sda_o;
        logic       sda_oe_n;
    } dev_st_t;

    localparam dev_st_t DEV_RST = '{
        state:    D_IDLE,
        kind:     K_ADDR,
        rd:       1'b0,
        scl_s:    3'h7,
        sda_s:    3'h7,
        pin_s:    3'h0,
        scl_f:    1'b1,
        sda_f:    1'b1,
        pin_f:    1'b0,
        bit_cnt:  4'h0,
        sh:       8'h00,
        ptr:      8'h00,
        snap:     6'h00,
        stat_en:  1'b1,
        r1:       `RST_CTRL,
        r2:       `RST_VBAT,
        r4:       `RST_ICHG,
        kick:     1'b0,
        hs:       1'b0,
        sda_o:    1'b0,
        sda_oe_n: 1'b1
    };

    dev_st_t q;
    dev_st_t d;
    logic    scl_n;
    logic    sda_n;
    logic    rise;
    logic    fall;
    logic    start;
    logic    stop;

    // read value for the register at the pointer
    function automatic logic [7:0] rd_val(input dev_st_t s);
        logic [7:0] v;
        v = `READ_MISS;                                           // [R08]
        if (s.ptr == `REG_STATUS) begin
            v = {s.pin_f, s.stat_en, s.snap};                     // [R18] [R19] [R20] [R21] [R22]
        end else if (s.ptr == `REG_CTRL) begin
            v = s.r1;                                             // [R17]
        end else if (s.ptr == `REG_VBAT) begin
            v = s.r2;
        end else if (s.ptr == `REG_PART) begin
            v = PART_ID;
        end else if (s.ptr == `REG_ICHG) begin
            v = s.r4;
        end
        return v;
    endfunction

    always_comb begin
        d = q;
        d.kick = 1'b0;
        d.sda_o = 1'b0;
        // three-stage synchronisers, change taken once stages two and three agree
        d.scl_s = {q.scl_s[1:0], link.scl};
        d.sda_s = {q.sda_s[1:0], link.sda};
        d.pin_s = {q.pin_s[1:0], boost_request_pin};
        scl_n = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
        sda_n = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
        d.scl_f = scl_n;
        d.sda_f = sda_n;
        d.pin_f = (q.pin_s[1] == q.pin_s[2]) ? q.pin_s[2] : q.pin_f;
        d.snap = {charge_state, boost_active, fault_code};       // [R20] [R21] [R22]
        rise = scl_n & ~q.scl_f;
        fall = ~scl_n & q.scl_f;
        start = q.scl_f & scl_n & q.sda_f & ~sda_n;               // [R01]
        stop = q.scl_f & scl_n & ~q.sda_f & sda_n;                // [R06]

        if (stop) begin
            d.state = D_IDLE;                                     // [R06] [R07]
            d.sda_oe_n = 1'b1;
            d.hs = 1'b0;                                          // [R12]
        end else if (start) begin
            d.state = D_RX;                                       // [R01] [R11]
            d.kind = K_ADDR;
            d.bit_cnt = 4'h0;
            d.sda_oe_n = 1'b1;
        end else begin
            case (q.state)
                D_RX: begin
                    if (rise && q.bit_cnt < 4'h8) begin
                        d.sh = {q.sh[6:0], sda_n};                // [R03]
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (fall && q.bit_cnt == 4'h8) begin
                        d.state = D_ACK;
                        d.sda_oe_n = 1'b0;                        // [R05] [R14]
                        if (q.kind == K_ADDR) begin
                            if (q.sh[7:3] == `HS_CODE_TOP) begin
                                d.hs = 1'b1;                      // [R10]
                                d.state = D_IDLE;
                                d.sda_oe_n = 1'b1;
                            end else if (q.sh[7:1] == SLAVE_ADDR) begin
                                d.rd = q.sh[0];                   // [R04] [R23] [R24]
                            end else begin
                                d.state = D_IDLE;
                                d.sda_oe_n = 1'b1;
                            end
                        end
                    end
                end
                D_ACK: begin
                    if (fall) begin
                        d.sda_oe_n = 1'b1;
                        d.bit_cnt = 4'h0;
                        d.state = D_RX;
                        case (q.kind)
                            K_ADDR: begin
                                if (q.rd) begin
                                    d.sh = rd_val(q);             // [R24]
                                    d.sda_oe_n = d.sh[7];
                                    d.state = D_TX;
                                end else begin
                                    d.kind = K_REG;               // [R17]
                                end
                            end
                            K_REG: begin
                                d.ptr = q.sh;
                                d.kind = K_DATA;
                            end
                            default: begin
                                d.kind = K_REG;                   // [R16]
                                if (q.ptr == `REG_STATUS) begin
                                    d.kick = q.sh[`STAT_KICK_BIT];   // [R15] [R18]
                                    d.stat_en = q.sh[`STAT_EN_BIT];  // [R19]
                                end else if (q.ptr == `REG_CTRL) begin
                                    d.r1 = q.sh;                  // [R15]
                                end else if (q.ptr == `REG_VBAT) begin
                                    d.r2 = q.sh;
                                end else if (q.ptr == `REG_ICHG) begin
                                    d.r4 = q.sh;
                                end
                            end
                        endcase
                    end
                end
                D_TX: begin
                    if (fall) begin
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == 4'h7) begin
                            d.sda_oe_n = 1'b1;                    // [R05]
                            d.state = D_TACK;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_oe_n = q.sh[6];                 // [R03]
                        end
                    end
                end
                D_TACK: begin
                    if (rise) begin
                        if (sda_n) begin
                            d.state = D_IDLE;
                        end else begin
                            d.bit_cnt = 4'h0;
                        end
                    end else if (fall && q.bit_cnt == 4'h0) begin
                        d.sh = rd_val(q);
                        d.sda_oe_n = d.sh[7];
                        d.state = D_TX;
                    end
                end
                default: begin
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    assign safety_timer_restart = q.kick;
    assign stat_pin_enable = q.stat_en;
    assign hs_mode = q.hs;
    assign link.sda_s_o = q.sda_o;
    assign link.sda_s_oe_n = q.sda_oe_n;
endmodule

// File: design/chg_link_defines.svh
`ifndef CHG_LINK_DEFINES_SVH
`define CHG_LINK_DEFINES_SVH

// slave addresses of the two device variants
`define SLV_ADDR_A      7'h6b
`define SLV_ADDR_B      7'h6a
// high-speed master code 00001xxx: top five bits
`define HS_CODE_TOP     5'h01
`define HS_CODE_BYTE    8'h08

// device register map
`define REG_STATUS      8'h00
`define REG_CTRL        8'h01
`define REG_VBAT        8'h02
`define REG_PART        8'h03
`define REG_ICHG        8'h04
`define RST_CTRL        8'h30
`define RST_VBAT        8'h0a
`define RST_ICHG        8'h01
`define STAT_KICK_BIT   7
`define STAT_EN_BIT     6
`define READ_MISS       8'hff

// timing: rates are maxima, so quarter periods round up
`define CLK_KHZ         40000
`define FS_KHZ          400
`define HS_KHZ          3400
`define FS_QTR          ((`CLK_KHZ + 4 * `FS_KHZ - 1) / (4 * `FS_KHZ))
`define HS_QTR          ((`CLK_KHZ + 4 * `HS_KHZ - 1) / (4 * `HS_KHZ))

// host controller register map
`define HOST_AW         3
`define HOST_SLV        3'h0
`define HOST_REG        3'h1
`define HOST_WDATA      3'h2
`define HOST_CTRL       3'h3
`define HOST_RDATA      3'h4
`define CTRL_GO_BIT     0
`define CTRL_READ_BIT   1
`define CTRL_HS_BIT     2
`define STS_BUSY_BIT    0
`define STS_NACK_BIT    1

`endif

// File: design/chg_link_pkg.sv
package chg_link_pkg;
    `include "chg_link_defines.svh"

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RX   = 3'b001,
        D_ACK  = 3'b011,
        D_TX   = 3'b010,
        D_TACK = 3'b110
    } dev_state_t;

    typedef enum logic [1:0] {
        K_ADDR = 2'b00,
        K_REG  = 2'b01,
        K_DATA = 2'b11
    } byte_kind_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_COND = 2'b01,
        H_BYTE = 2'b11,
        H_STOP = 2'b10
    } host_state_t;

    typedef enum logic [3:0] {
        S_START     = 4'h0,
        S_CODE      = 4'h1,
        S_RSTART_HS = 4'h2,
        S_ADDR_W    = 4'h3,
        S_REG       = 4'h4,
        S_DATA      = 4'h5,
        S_RSTART_RD = 4'h6,
        S_ADDR_R    = 4'h7,
        S_READ      = 4'h8,
        S_STOP      = 4'h9
    } step_t;
endpackage

// File: design/i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;
    logic scl_m_o;      // master scl drive value
    logic scl_m_oe_n;   // master scl enable, low drives
    logic sda_m_o;      // master sda drive value
    logic sda_m_oe_n;   // master sda enable, low drives
    logic sda_s_o;      // slave sda drive value
    logic sda_s_oe_n;   // slave sda enable, low drives
    logic scl;          // resolved wire level
    logic sda;          // resolved wire level

    // open-drain wires with pull-ups
    assign scl = scl_m_oe_n | scl_m_o;
    assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

    modport master (output scl_m_o, scl_m_oe_n, sda_m_o, sda_m_oe_n, input scl, sda);
    modport slave  (output sda_s_o, sda_s_oe_n, input scl, sda);
endinterface

// File: design/i2c_host_master.sv
`timescale 1ns/1ps
`include "chg_link_defines.svh"
module i2c_host_master
    import chg_link_pkg::*;
#(
    parameter int FS_QTR = `FS_QTR,   // clocks per quarter bit, fs
    parameter int HS_QTR = `HS_QTR    // clocks per quarter bit, hs
) (
    input  wire logic                 clk,      // 40 mhz clock
    input  wire logic                 sys_rst,  // sync reset, high
    i2c_link_if.master                link,     // two-wire bus
    input  wire logic [`HOST_AW-1:0]  addr,     // register address
    input  wire logic [7:0]           wdata,    // write data
    input  wire logic                 wr,       // write strobe
    input  wire logic                 rd,       // read strobe
    output logic [7:0]                rdata     // read data, next cycle
);
    import chg_link_pkg::*;

    typedef struct packed {
        host_state_t state;
        step_t       step;
        logic [1:0]  phase;
        logic [7:0]  cnt;
        logic [3:0]  bit_cnt;
        logic [7:0]  sh;
        logic [7:0]  rx;
        logic [6:0]  slv;
        logic [7:0]  rg;
        logic [7:0]  wd;
        logic        rd_op;
        logic        hs_req;
        logic        hs;
        logic        busy;
        logic        nack;
        logic [7:0]  rdata;
        logic [2:0]  sda_s;
        logic        sda_f;
        logic        scl_o;
        logic        scl_oe_n;
        logic        sda_o;
        logic        sda_oe_n;
    } host_st_t;

    localparam host_st_t HOST_RST = '{
        state: H_IDLE, step: S_START, phase: 2'h0, cnt: 8'h00, bit_cnt: 4'h0, sh: 8'h00, rx: 8'h00,
        slv: `SLV_ADDR_A, rg: 8'h00, wd: 8'h00, rd_op: 1'b0, hs_req: 1'b0, hs: 1'b0, busy: 1'b0,
        nack: 1'b0, rdata: 8'h00, sda_s: 3'h7, sda_f: 1'b1, scl_o: 1'b0, scl_oe_n: 1'b1, sda_o: 1'b0,
        sda_oe_n: 1'b1
    };
    localparam logic [7:0] FS_LIM = 8'(FS_QTR - 1);
    localparam logic [7:0] HS_LIM = 8'(HS_QTR - 1);

    host_st_t q;
    host_st_t d;
    logic [7:0] lim;

    function automatic step_t next_step(input host_st_t s);
        case (s.step)
            S_START:     return s.hs_req ? S_CODE : S_ADDR_W;
            S_CODE:      return S_RSTART_HS;                        // [R11]
            S_RSTART_HS: return S_ADDR_W;
            S_ADDR_W:    return S_REG;                              // [R14]
            S_REG:       return s.rd_op ? S_RSTART_RD : S_DATA;
            S_RSTART_RD: return S_ADDR_R;                           // [R13]
            S_ADDR_R:    return S_READ;
            default:     return S_STOP;
        endcase
    endfunction

    // enter a step with pins set for its phase zero
    function automatic host_st_t launch(input host_st_t s, input step_t st);
        host_st_t r;
        r = s;
        r.step = st;
        r.phase = 2'h0;
        r.cnt = 8'h00;
        r.bit_cnt = 4'h0;
        r.scl_oe_n = 1'b0;
        r.sda_oe_n = 1'b1;
        case (st)
            S_START, S_RSTART_HS, S_RSTART_RD: r.state = H_COND;
            S_STOP: begin
                r.state = H_STOP;
                r.sda_oe_n = 1'b0;
            end
            default: begin
                r.state = H_BYTE;
                case (st)
                    S_CODE:   r.sh = `HS_CODE_BYTE;                 // [R09]
                    S_ADDR_W: r.sh = {s.slv, 1'b0};                 // [R02] [R24]
                    S_REG:    r.sh = s.rg;
                    S_DATA:   r.sh = s.wd;
                    S_ADDR_R: r.sh = {s.slv, 1'b1};
                    default:  r.sh = 8'hff;
                endcase
                r.sda_oe_n = r.sh[7];                               // [R03]
            end
        endcase
        return r;
    endfunction

    always_comb begin
        d = q;
        d.rdata = 8'h00;
        d.scl_o = 1'b0;
        d.sda_o = 1'b0;
        d.sda_s = {q.sda_s[1:0], link.sda};
        d.sda_f = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
        lim = q.hs ? HS_LIM : FS_LIM;                               // [R09] [R11]

        if (rd) begin
            if (addr == `HOST_SLV) begin
                d.rdata = {1'b0, q.slv};
            end else if (addr == `HOST_REG) begin
                d.rdata = q.rg;
            end else if (addr == `HOST_WDATA) begin
                d.rdata = q.wd;
            end else if (addr == `HOST_CTRL) begin
                d.rdata = {6'h00, q.nack, q.busy};
            end else if (addr == `HOST_RDATA) begin
                d.rdata = q.rx;
            end
        end

        if (q.state != H_IDLE) begin
            d.cnt = q.cnt + 8'h01;
            if (q.cnt >= lim) begin
                d.cnt = 8'h00;
                d.phase = q.phase + 2'h1;
                case (q.state)
                    H_COND: begin
                        case (q.phase)
                            // two quarters low, so a slave ack is gone before scl rises
                            2'h0: ;
                            2'h1: d.scl_oe_n = 1'b1;
                            2'h2: d.sda_oe_n = 1'b0;                // [R01] [R11]
                            default: d = launch(d, next_step(q));
                        endcase
                    end
                    H_STOP: begin
                        case (q.phase)
                            2'h0: ;
                            2'h1: d.scl_oe_n = 1'b1;
                            2'h2: d.sda_oe_n = 1'b1;                // [R06]
                            default: begin
                                d.state = H_IDLE;
                                d.busy = 1'b0;
                                d.hs = 1'b0;
                            end
                        endcase
                    end
                    default: begin
                        case (q.phase)
                            2'h0: ;
                            2'h1: d.scl_oe_n = 1'b1;
                            2'h2: ;
                            default: begin
                                d.scl_oe_n = 1'b0;
                                if (q.bit_cnt < 4'h8) begin
                                    d.rx = {q.rx[6:0], q.sda_f};
                                    d.sh = {q.sh[6:0], 1'b1};
                                    d.bit_cnt = q.bit_cnt + 4'h1;
                                    // ninth bit: release for ack, or nack after the read byte
                                    d.sda_oe_n = (q.bit_cnt == 4'h7) ? 1'b1 : q.sh[6];   // [R05]
                                end else if (q.step == S_CODE) begin
                                    d.hs = 1'b1;                    // [R10]
                                    d = launch(d, next_step(q));
                                end else if (q.sda_f && q.step != S_READ) begin
                                    d.nack = 1'b1;
                                    d = launch(d, S_STOP);          // [R07]
                                end else begin
                                    d = launch(d, next_step(q));
                                end
                            end
                        endcase
                    end
                endcase
            end
        end

        if (wr) begin
            if (addr == `HOST_SLV) begin
                d.slv = wdata[6:0];
            end else if (addr == `HOST_REG) begin
                d.rg = wdata;
            end else if (addr == `HOST_WDATA) begin
                d.wd = wdata;
            end else if (addr == `HOST_CTRL && wdata[`CTRL_GO_BIT] && !q.busy) begin
                d.rd_op = wdata[`CTRL_READ_BIT];
                d.hs_req = wdata[`CTRL_HS_BIT];
                d.busy = 1'b1;
                d.nack = 1'b0;
                d = launch(d, S_START);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= HOST_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign link.scl_m_o = q.scl_o;
    assign link.scl_m_oe_n = q.scl_oe_n;
    assign link.sda_m_o = q.sda_o;
    assign link.sda_m_oe_n = q.sda_oe_n;
endmodule

// File: tb/charger_i2c_slave_status_port_asserts.sv
`timescale 1ns/1ps
module charger_i2c_slave_status_port_asserts (
    input wire logic clk,       // 40 mhz clock
    input wire logic sys_rst,   // sync reset, high
    input wire logic scl,       // resolved clock wire
    input wire logic sda,       // resolved data wire
    input wire logic sda_s_oe_n // slave data enable
);
    logic [3:0] rises_q;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // scl rises since the last start, saturating
    always_ff @(posedge clk) begin
        if (sys_rst || (scl && $past(scl) && $fell(sda)))
            rises_q <= 4'h0;
        else if ($rose(scl) && rises_q != 4'hf)
            rises_q <= rises_q + 4'h1;
    end

    property p_slave_edge; $changed(sda_s_oe_n) |-> !scl; endproperty
    a_slave_edge: assert property (p_slave_edge) else $error("slave data moved with scl high");
    property p_ack_hold; $rose(scl) && !sda_s_oe_n |-> !sda_s_oe_n[*5]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("slave low not held over high");
    property p_addr_listen; $rose(scl) && rises_q < 4'h8 |-> sda_s_oe_n; endproperty
    a_addr_listen: assert property (p_addr_listen) else $error("slave drove during address");
    property p_start_free; scl && $past(scl) && $fell(sda) |-> sda_s_oe_n; endproperty
    a_start_free: assert property (p_start_free) else $error("slave drove at start");
    property p_stop_release; scl && $past(scl) && $rose(sda) |-> sda_s_oe_n[*8]; endproperty
    a_stop_release: assert property (p_stop_release) else $error("slave drove after stop");
    property p_low_phase; $fell(scl) |-> !scl[*6]; endproperty
    a_low_phase: assert property (p_low_phase) else $error("scl low phase too short");
    property p_high_phase; $rose(scl) |-> scl[*6]; endproperty
    a_high_phase: assert property (p_high_phase) else $error("scl high phase too short");
    property p_idle; $fell(sys_rst) |-> scl && sda; endproperty
    a_idle: assert property (p_idle) else $error("bus not idle after reset");

    c_start: cover property (scl && $past(scl) && $fell(sda));
    c_ack: cover property ($rose(scl) && !sda_s_oe_n && rises_q == 4'h8);
    c_stop: cover property (scl && $past(scl) && $rose(sda));
endmodule

// File: tb/charger_i2c_slave_status_port_test.sv
`timescale 1ns/1ps
`include "chg_link_defines.svh"
module charger_i2c_slave_status_port_test;
    import chg_link_pkg::*;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       boost_request_pin = 1'b0;
    logic [1:0] charge_state = 2'h0;
    logic       boost_active = 1'b0;
    logic [2:0] fault_code = 3'h0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       safety_timer_restart;
    logic       stat_pin_enable;
    logic       hs_mode;
    int         err_count = 0;
    int         total_checks = 0;
    int         kicks = 0;
    int         hs_cnt = 0;
    int         cycles = 0;

    i2c_link_if link ();
    charger_i2c_slave charger_i2c_slave_inst (.clk, .sys_rst, .link(link), .boost_request_pin, .charge_state,
        .boost_active, .fault_code, .safety_timer_restart, .stat_pin_enable, .hs_mode);
    i2c_host_master i2c_host_master_inst (.clk, .sys_rst, .link(link), .addr, .wdata, .wr, .rd, .rdata);
    charger_i2c_slave_status_port_asserts charger_i2c_slave_status_port_asserts_inst (.clk, .sys_rst,
        .scl(link.scl), .sda(link.sda), .sda_s_oe_n(link.sda_s_oe_n));

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (safety_timer_restart === 1'b1) kicks++;
        if (hs_mode === 1'b1) hs_cnt++;
        if (cycles == 90000) begin
            err_count++;
            close_out();
        end
    end

    task close_out;
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task hw(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task hr(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // one host transaction, polled until idle; returns busy/nack
    task xfer(input logic [7:0] r, input logic [7:0] d, input logic [7:0] c, output logic [7:0] st);
        hw(`HOST_REG, r);
        hw(`HOST_WDATA, d);
        hw(`HOST_CTRL, c);
        st = 8'h01;
        while (st[`STS_BUSY_BIT] !== 1'b0) hr(`HOST_CTRL, st);
        st = {6'h0, st[1:0]};
    endtask

    task rw(input logic [7:0] r, input logic w, input logic [7:0] d, input logic [7:0] e);
        logic [7:0] st;
        logic [7:0] v;
        if (w) xfer(r, d, 8'h01, st);
        xfer(r, 8'h00, 8'h03, st);
        hr(`HOST_RDATA, v);
        check(v, e);
    endtask

    // every state and fault code, odd passes in high-speed mode
    task t_status;
        logic [7:0] st;
        logic [7:0] v;
        int h0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            boost_request_pin <= i[1];
            charge_state <= i[1:0];
            boost_active <= i[2];
            fault_code <= i[2:0];
            h0 = hs_cnt;
            xfer(`REG_STATUS, 8'h00, {5'h0, i[0], 2'h3}, st);
            check(st, 8'h00);
            hr(`HOST_RDATA, v);
            check(v, {i[1], 1'b1, i[1:0], i[2], i[2:0]});
            check({7'h0, hs_cnt != h0}, {7'h0, i[0]});
            check({7'h0, hs_mode}, 8'h00);
        end
    endtask

    task t_kick;
        logic [7:0] st;
        int k0;
        k0 = kicks;
        xfer(`REG_STATUS, 8'h80, 8'h01, st);
        check(8'(kicks - k0), 8'h01);
        check({7'h0, stat_pin_enable}, 8'h00);
        xfer(`REG_STATUS, 8'h40, 8'h01, st);
        check(8'(kicks - k0), 8'h01);
        check({7'h0, stat_pin_enable}, 8'h01);
    endtask

    task t_nack;
        logic [7:0] st;
        logic [7:0] v;
        hw(`HOST_SLV, 8'h6a);
        xfer(`REG_STATUS, 8'h00, 8'h01, st);
        check(st, 8'h02);
        hw(`HOST_SLV, 8'h6b);
        hr(3'h5, v);
        check(v, 8'h00);
    endtask

    task t_regs;
        rw(`REG_CTRL, 1'b0, 8'h00, `RST_CTRL);
        rw(`REG_ICHG, 1'b0, 8'h00, `RST_ICHG);
        rw(`REG_VBAT, 1'b1, 8'ha5, 8'ha5);
        rw(`REG_ICHG, 1'b1, 8'h3c, 8'h3c);
        rw(`REG_PART, 1'b1, 8'h55, 8'h00);
        rw(8'h07, 1'b0, 8'h00, `READ_MISS);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_status;
        t_kick;
        t_nack;
        t_regs;
        close_out;
    end
endmodule
